// ==== dpr_pkg.sv ====
/*
  Package for the digital I/O pin routing port: register addresses,
  field positions, reset values, routing codes and carrier structs.
  Assumes the processor reaches the registers through its own
  special function and configuration RAM address space.
*/
package dpr_pkg;

  // Special function register addresses of the port registers
  localparam logic [15:0] DPR_ADDR_PORT_PINS_3_0 = 16'h0080;
  localparam logic [15:0] DPR_ADDR_PORT_PINS_7_4 = 16'h0090;
  localparam logic [15:0] DPR_ADDR_PORT_PINS_11_8 = 16'h00A0;
  localparam logic [15:0] DPR_ADDR_PORT_PINS_14_12 = 16'h00B0;
  // Configuration RAM addresses
  localparam logic [15:0] DPR_ADDR_RPB = 16'h2450;
  localparam logic [15:0] DPR_ADDR_RA = 16'h2451;
  localparam logic [15:0] DPR_ADDR_RB = 16'h2452;
  localparam logic [15:0] DPR_ADDR_RC = 16'h2453;
  localparam logic [15:0] DPR_ADDR_RD = 16'h2454;
  localparam logic [15:0] DPR_ADDR_RE = 16'h2455;
  localparam logic [15:0] DPR_ADDR_EEX = 16'h2456;
  localparam logic [15:0] DPR_ADDR_PULSE = 16'h2457;

  // Field positions
  localparam int DPR_DIR_LSB = 4;
  localparam int DPR_VAL_LSB = 0;
  localparam int DPR_SEL_LO_LSB = 0;
  localparam int DPR_SEL_HI_LSB = 4;
  localparam int DPR_EEX_LSB = 6;
  localparam int DPR_PW_BIT = 7;

  // Widths
  localparam int DPR_NPINS = 15;
  localparam int DPR_NSEL = 11;   // Pins 2..11 plus the pushbutton

  // Reset values
  localparam logic [14:0] DPR_DIR_RST = 15'h7FFF;
  localparam logic [14:0] DPR_VAL_RST = 15'h7FFF;
  localparam logic [2:0] DPR_SEL_RST = 3'h0;
  localparam logic [1:0] DPR_EEX_RST = 2'h0;
  localparam logic DPR_PW_RST = 1'b0;

  // Resource selector codes
  typedef enum logic [2:0] {
    DPR_RES_NONE = 3'b000,
    DPR_RES_RSVD = 3'b001,
    DPR_RES_TMR0 = 3'b010,
    DPR_RES_TMR1 = 3'b011,
    DPR_RES_FIRST_EXTERNAL_INTERRUPT = 3'b100,
    DPR_RES_SECOND_EXTERNAL_INTERRUPT = 3'b101
  } dpr_res_type;

  // EEPROM pin modes
  typedef enum logic [1:0] {
    DPR_EE_OFF = 2'b00,
    DPR_EE_TWO = 2'b01,
    DPR_EE_THREE = 2'b10,
    DPR_EE_THREE_SEP = 2'b11
  } dpr_ee_type;

  // Processor register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dpr_bus_req_type;

  // Routed internal resources
  typedef struct packed {
    logic first_timer_input;
    logic second_timer_input;
    logic first_external_interrupt;
    logic second_external_interrupt;
  } dpr_res_out_type;

  // Serial EEPROM engine signals on the core side
  typedef struct packed {
    logic clk_out;
    logic data_out;
    logic data_oe_n;
  } dpr_ee_core_type;

endpackage : dpr_pkg

// ==== dpr_route.sv ====
/*
  Resource router: ORs synchronised pin levels into the timer and
  interrupt inputs according to the three-bit selectors.
  Assumes the pin levels are already synchronised to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dpr_route
  import dpr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [DPR_NSEL-1:0] src_level,
  input wire logic [DPR_NSEL*3-1:0] src_sel,
  output dpr_res_out_type res_q
);

  // Test one selector against a resource code
  function automatic logic sel_is(input logic [2:0] s, input dpr_res_type r);
    sel_is = (s == r);
  endfunction : sel_is

  dpr_res_out_type res_d;

  // OR every source whose selector names each resource
  always_comb begin
    res_d = '0;
    for (int i = 0; i < DPR_NSEL; i++) begin
      if (sel_is(src_sel[i*3 +: 3], DPR_RES_TMR0)) begin
        res_d.first_timer_input = res_d.first_timer_input | src_level[i];
      end
      if (sel_is(src_sel[i*3 +: 3], DPR_RES_TMR1)) begin
        res_d.second_timer_input = res_d.second_timer_input | src_level[i];
      end
      if (sel_is(src_sel[i*3 +: 3], DPR_RES_FIRST_EXTERNAL_INTERRUPT)) begin
        res_d.first_external_interrupt =
          res_d.first_external_interrupt | src_level[i];
      end
      if (sel_is(src_sel[i*3 +: 3], DPR_RES_SECOND_EXTERNAL_INTERRUPT)) begin
        res_d.second_external_interrupt =
          res_d.second_external_interrupt | src_level[i];
      end
    end
  end

  // Registered resource outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

  a_route_or_one: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (sel_is(src_sel[2:0], DPR_RES_FIRST_EXTERNAL_INTERRUPT) && src_level[0])
    |=> res_q.first_external_interrupt)
    else $error("interrupt input missed an active source");
  a_route_none: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (src_sel == '0) |=> (res_q == '0))
    else $error("resource driven with no selector set");

endmodule : dpr_route
`default_nettype wire

// ==== dpr_port.sv ====
/*
  Digital I/O pin routing port: direction and value registers for
  fifteen pins, resource selectors, EEPROM pin takeover and energy
  pulse output on pin 0. Assumes a single-cycle processor register
  strobe on ref_clk and an EEPROM engine and pulse source elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none
module dpr_port
  import dpr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire dpr_bus_req_type bus_req,
  output logic [7:0] bus_rdata_q,
  input wire logic [DPR_NPINS-1:0] pin_in,
  output logic [DPR_NPINS-1:0] pin_out,
  output logic [DPR_NPINS-1:0] pin_oe_n,
  input wire logic pushbutton_input,
  input wire logic energy_pulse,
  input wire dpr_ee_core_type ee_core,
  output logic eeprom_in_line_q,
  output logic [1:0] eeprom_pin_mode,
  output dpr_res_out_type res_q
);

  logic [DPR_NPINS-1:0] pin_direction_q;
  logic [DPR_NPINS-1:0] value_q;
  logic [2:0] button_resource_select_q;
  logic [2:0] pin_resource_select_q [2:11];
  logic [1:0] eeprom_pin_mode_q;
  logic energy_pulse_output_select_q;
  logic [DPR_NPINS-1:0] sync1_q;
  logic [DPR_NPINS-1:0] sync2_q;
  logic [DPR_NPINS-1:0] sync3_q;
  logic [DPR_NPINS-1:0] level_q;
  logic [2:0] pb_sync_q;
  logic pb_level_q;
  logic [DPR_NPINS-1:0] pin_out_d;
  logic [DPR_NPINS-1:0] pin_oe_n_d;
  logic [DPR_NPINS-1:0] pin_out_q;
  logic [DPR_NPINS-1:0] pin_oe_n_q;
  logic [DPR_NSEL-1:0] src_level;
  logic [DPR_NSEL*3-1:0] src_sel;
  logic ee_on;
  logic [7:0] rdata_d;

  // Port register index for a nibble group, or 4 when not a port
  function automatic logic [2:0] port_index(input logic [15:0] a);
    unique case (a)
      DPR_ADDR_PORT_PINS_3_0: port_index = 3'h0;
      DPR_ADDR_PORT_PINS_7_4: port_index = 3'h1;
      DPR_ADDR_PORT_PINS_11_8: port_index = 3'h2;
      DPR_ADDR_PORT_PINS_14_12: port_index = 3'h3;
      default: port_index = 3'h4;
    endcase
  endfunction : port_index

  assign ee_on = (eeprom_pin_mode_q != DPR_EE_OFF);
  assign eeprom_pin_mode = eeprom_pin_mode_q;

  // Three-stage synchroniser on pins and the pushbutton
  // Pin stages reset to the driven-high level so no false change follows
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_q <= DPR_VAL_RST;
      sync2_q <= DPR_VAL_RST;
      sync3_q <= DPR_VAL_RST;
      pb_sync_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pb_sync_q <= {pb_sync_q[1:0], pushbutton_input};
    end
  end

  // Accept a level once the second and third stages agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      level_q <= DPR_VAL_RST;
      pb_level_q <= 1'b0;
    end else begin
      for (int i = 0; i < DPR_NPINS; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          level_q[i] <= sync3_q[i];
        end
      end
      if (pb_sync_q[1] == pb_sync_q[2]) begin
        pb_level_q <= pb_sync_q[2];
      end
    end
  end

  // Port registers: direction upper nibble, value lower nibble
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_direction_q <= DPR_DIR_RST;
      value_q <= DPR_VAL_RST;
    end else if (bus_req.wr && port_index(bus_req.addr) != 3'h4) begin
      for (int p = 0; p < DPR_NPINS; p++) begin
        if (int'(port_index(bus_req.addr)) == p / 4) begin
          pin_direction_q[p] <= bus_req.wdata[DPR_DIR_LSB + p % 4];
          // Input pins ignore value writes
          if (bus_req.wdata[DPR_DIR_LSB + p % 4]) begin
            value_q[p] <= bus_req.wdata[DPR_VAL_LSB + p % 4];
          end
        end
      end
    end
  end

  // Resource selectors and special function configuration
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      button_resource_select_q <= DPR_SEL_RST;
      for (int k = 2; k <= 11; k++) begin
        pin_resource_select_q[k] <= DPR_SEL_RST;
      end
      eeprom_pin_mode_q <= DPR_EEX_RST;
      energy_pulse_output_select_q <= DPR_PW_RST;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        DPR_ADDR_RPB:
          button_resource_select_q <= bus_req.wdata[DPR_SEL_LO_LSB +: 3];
        DPR_ADDR_RA: begin
          pin_resource_select_q[10] <= bus_req.wdata[DPR_SEL_LO_LSB +: 3];
          pin_resource_select_q[11] <= bus_req.wdata[DPR_SEL_HI_LSB +: 3];
        end
        DPR_ADDR_RB: begin
          pin_resource_select_q[8] <= bus_req.wdata[DPR_SEL_LO_LSB +: 3];
          pin_resource_select_q[9] <= bus_req.wdata[DPR_SEL_HI_LSB +: 3];
        end
        DPR_ADDR_RC: begin
          pin_resource_select_q[6] <= bus_req.wdata[DPR_SEL_LO_LSB +: 3];
          pin_resource_select_q[7] <= bus_req.wdata[DPR_SEL_HI_LSB +: 3];
        end
        DPR_ADDR_RD: begin
          pin_resource_select_q[4] <= bus_req.wdata[DPR_SEL_LO_LSB +: 3];
          pin_resource_select_q[5] <= bus_req.wdata[DPR_SEL_HI_LSB +: 3];
        end
        DPR_ADDR_RE: begin
          pin_resource_select_q[2] <= bus_req.wdata[DPR_SEL_LO_LSB +: 3];
          pin_resource_select_q[3] <= bus_req.wdata[DPR_SEL_HI_LSB +: 3];
        end
        DPR_ADDR_EEX:
          eeprom_pin_mode_q <= bus_req.wdata[DPR_EEX_LSB +: 2];
        DPR_ADDR_PULSE:
          energy_pulse_output_select_q <= bus_req.wdata[DPR_PW_BIT];
        default: ;
      endcase
    end
  end

  // Read mux: port value bits return the sampled pin level
  always_comb begin
    rdata_d = 8'h00;
    unique case (bus_req.addr)
      DPR_ADDR_PORT_PINS_3_0:
        rdata_d = {pin_direction_q[3:0], level_q[3:0]};
      DPR_ADDR_PORT_PINS_7_4: rdata_d = {pin_direction_q[7:4], level_q[7:4]};
      DPR_ADDR_PORT_PINS_11_8: rdata_d = {pin_direction_q[11:8], level_q[11:8]};
      DPR_ADDR_PORT_PINS_14_12:
        rdata_d = {1'b0, pin_direction_q[14:12], 1'b0, level_q[14:12]};
      DPR_ADDR_RPB: rdata_d = {5'h00, button_resource_select_q};
      DPR_ADDR_RA: rdata_d = {1'b0, pin_resource_select_q[11],
                              1'b0, pin_resource_select_q[10]};
      DPR_ADDR_RB: rdata_d = {1'b0, pin_resource_select_q[9],
                              1'b0, pin_resource_select_q[8]};
      DPR_ADDR_RC: rdata_d = {1'b0, pin_resource_select_q[7],
                              1'b0, pin_resource_select_q[6]};
      DPR_ADDR_RD: rdata_d = {1'b0, pin_resource_select_q[5],
                              1'b0, pin_resource_select_q[4]};
      DPR_ADDR_RE: rdata_d = {1'b0, pin_resource_select_q[3],
                              1'b0, pin_resource_select_q[2]};
      DPR_ADDR_EEX: rdata_d = {eeprom_pin_mode_q, 6'h00};
      DPR_ADDR_PULSE: rdata_d = {energy_pulse_output_select_q, 7'h00};
      default: rdata_d = 8'h00;
    endcase
  end

  // Registered read data, updated on a read strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_rdata_q <= 8'h00;
    end else if (bus_req.rd) begin
      bus_rdata_q <= rdata_d;
    end
  end

  // Pin drivers with EEPROM and pulse takeover
  always_comb begin
    pin_out_d = value_q;
    pin_oe_n_d = ~pin_direction_q;
    if (energy_pulse_output_select_q) begin
      pin_out_d[0] = energy_pulse;
      pin_oe_n_d[0] = 1'b0;
    end
    if (ee_on) begin
      pin_out_d[2] = ee_core.clk_out;
      pin_oe_n_d[2] = 1'b0;
      pin_out_d[3] = ee_core.data_out;
      pin_oe_n_d[3] = ee_core.data_oe_n;
    end
    if (eeprom_pin_mode_q == DPR_EE_THREE_SEP) begin
      pin_out_d[8] = 1'b0;
      pin_oe_n_d[8] = 1'b1;
    end
  end

  // Registered pin outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_out_q <= DPR_VAL_RST;
      pin_oe_n_q <= ~DPR_DIR_RST;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end
  assign pin_out = pin_out_q;
  assign pin_oe_n = pin_oe_n_q;

  // EEPROM data input: pin 8 in mode 11, shared pin 3 otherwise
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eeprom_in_line_q <= 1'b1;
    end else if (eeprom_pin_mode_q == DPR_EE_THREE_SEP) begin
      eeprom_in_line_q <= level_q[8];
    end else begin
      eeprom_in_line_q <= level_q[3];
    end
  end

  // Gather selectors; pins 2 and 3 feed no resource while EEPROM is on, pin 8 still does
  always_comb begin
    src_level = '0;
    src_sel = '0;
    src_level[0] = pb_level_q;
    src_sel[2:0] = button_resource_select_q;
    for (int k = 2; k <= 11; k++) begin
      src_level[k-1] = level_q[k];
      src_sel[(k-1)*3 +: 3] = pin_resource_select_q[k];
    end
    if (ee_on) begin
      src_sel[5:3] = 3'h0;
      src_sel[8:6] = 3'h0;
    end
  end

  // Resource router
  dpr_route u_route (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .src_level(src_level),
    .src_sel(src_sel),
    .res_q(res_q)
  );

  // Reset state of the port and mode registers
  a_dir_reset: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> (pin_direction_q == DPR_DIR_RST))
    else $error("direction bits not ones after reset");
  a_val_reset: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> (value_q == DPR_VAL_RST))
    else $error("value bits not ones after reset");
  a_mode_reset: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> (eeprom_pin_mode_q == DPR_EEX_RST))
    else $error("eeprom mode not off after reset");

  // Port register writes and reads
  a_dir_write: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == DPR_ADDR_PORT_PINS_3_0)
    |=> (pin_direction_q[3:0] == $past(bus_req.wdata[7:4])))
    else $error("direction write not taken");
  a_val_output_write: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == DPR_ADDR_PORT_PINS_7_4 && bus_req.wdata[4])
    |=> (value_q[4] == $past(bus_req.wdata[0])))
    else $error("output pin value write lost");
  a_val_input_hold: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == DPR_ADDR_PORT_PINS_7_4 && !bus_req.wdata[4])
    |=> (value_q[4] == $past(value_q[4])))
    else $error("input pin value changed by write");
  a_read_level: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == DPR_ADDR_PORT_PINS_3_0)
    |=> (bus_rdata_q[3:0] == $past(level_q[3:0])))
    else $error("port read not pin level");

  // Pin drivers and takeover
  a_oe_follows_dir: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (!ee_on && !energy_pulse_output_select_q)
    |=> (pin_oe_n_q[3:0] == ~$past(pin_direction_q[3:0])))
    else $error("enable does not follow direction");
  a_pulse_drive: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    energy_pulse_output_select_q
    |=> (!pin_oe_n_q[0] && pin_out_q[0] == $past(energy_pulse)))
    else $error("pulse not on pin 0");
  a_ee_clock_pin: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ee_on |=> (!pin_oe_n_q[2] && pin_out_q[2] == $past(ee_core.clk_out)))
    else $error("eeprom clock not on pin 2");
  a_ee_data_pin: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ee_on |=> (pin_out_q[3] == $past(ee_core.data_out)
      && pin_oe_n_q[3] == $past(ee_core.data_oe_n)))
    else $error("eeprom data not on pin 3");
  a_ee_off_free: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (!ee_on) |=> (pin_oe_n_q[2] == !$past(pin_direction_q[2])))
    else $error("pin 2 taken while eeprom off");

  // EEPROM data input selection
  a_ee_sep_input: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (eeprom_pin_mode_q == DPR_EE_THREE_SEP)
    |=> (pin_oe_n_q[8] && eeprom_in_line_q == $past(level_q[8])))
    else $error("pin 8 not eeprom input");
  a_ee_shared_input: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (eeprom_pin_mode_q != DPR_EE_THREE_SEP)
    |=> (eeprom_in_line_q == $past(level_q[3])))
    else $error("eeprom input not from pin 3");

  // Main scenarios
  c_ee_sep: cover property (@(posedge ref_clk)
    eeprom_pin_mode_q == DPR_EE_THREE_SEP);
  c_ee_three: cover property (@(posedge ref_clk)
    eeprom_pin_mode_q == DPR_EE_THREE);
  c_pulse: cover property (@(posedge ref_clk)
    energy_pulse_output_select_q && energy_pulse);
  c_first_external_interrupt: cover property (@(posedge ref_clk) res_q.first_external_interrupt);
  c_shared_int: cover property (@(posedge ref_clk)
    pb_level_q && level_q[11] && res_q.first_external_interrupt);

endmodule : dpr_port
`default_nettype wire

// ==== dpr_pins_model.sv ====
/*
  Far-side model of the fifteen port pins: resolves each pin from the
  device drive and an external source chosen by the bench.
  Assumes pin_oe_n is low while the device drives a pin.
*/
`timescale 1ns/1ps
`default_nettype none
module dpr_pins_model
  import dpr_pkg::*;
(
  input wire logic [DPR_NPINS-1:0] pin_out,
  input wire logic [DPR_NPINS-1:0] pin_oe_n,
  input wire logic [DPR_NPINS-1:0] ext_lvl,
  output logic [DPR_NPINS-1:0] pin_in
);
  // Device drive wins while enabled, else the external source shows
  always_comb begin
    for (int i = 0; i < DPR_NPINS; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
    end
  end
endmodule : dpr_pins_model
`default_nettype wire

// ==== dpr_port_bench.sv ====
/*
  Self-checking bench for the pin routing port: register reads are
  noted in a queue and compared by a monitor; pin and resource
  outputs are compared directly. Assumes the package of the port.
*/
`timescale 1ns/1ps
`default_nettype none
module dpr_port_bench
  import dpr_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  dpr_bus_req_type bus_req = '0;
  logic [7:0] bus_rdata_q;
  logic [DPR_NPINS-1:0] pin_in;
  logic [DPR_NPINS-1:0] pin_out;
  logic [DPR_NPINS-1:0] pin_oe_n;
  logic [DPR_NPINS-1:0] ext_lvl = '0;
  logic pushbutton_input = 1'b0;
  logic energy_pulse = 1'b0;
  dpr_ee_core_type ee_core = '0;
  logic eeprom_in_line_q;
  logic [1:0] eeprom_pin_mode;
  dpr_res_out_type res_q;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  int err_total = 0;
  int samples_checked = 0;
  int seed = 32'h30cb;
  logic [14:0] rnd;

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  dpr_port dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_rdata_q(bus_rdata_q), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pushbutton_input(pushbutton_input),
    .energy_pulse(energy_pulse), .ee_core(ee_core),
    .eeprom_in_line_q(eeprom_in_line_q),
    .eeprom_pin_mode(eeprom_pin_mode), .res_q(res_q)
  );

  dpr_pins_model pins_u (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl),
    .pin_in(pin_in)
  );

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic chk_rd(input logic [7:0] exp);
    samples_checked++;
    if (bus_rdata_q !== exp) begin
      err_total++;
      $display("CHECK FAILED bus_rdata_q expected %h seen %h", exp,
               bus_rdata_q);
    end
  endtask : chk_rd

  task automatic chk_sig(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_sig

  // Bus cycles: request held until the taking edge, then next step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_req = '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    #1;
  endtask : rd

  task automatic idle(input int n);
    bus_req = '0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  // Expected resource vector for one selector code
  function automatic logic [3:0] res_exp(input logic [2:0] c);
    case (c)
      3'h2: return 4'h8;
      3'h3: return 4'h4;
      3'h4: return 4'h2;
      3'h5: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction : res_exp

  // Read monitor: the oldest note is compared when data lands
  always @(posedge ref_clk) rd_seen <= bus_req.rd && rst_n;
  always @(negedge ref_clk) begin
    if (rd_seen && exp_q.size() > 0) chk_rd(exp_q.pop_front());
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    chk_sig("pin_oe_n", 16'h0000, {1'b0, pin_oe_n});
    chk_sig("pin_out", 16'h7FFF, {1'b0, pin_out});
    chk_sig("res_q", 16'h0000, {12'h0, res_q});
    chk_sig("ee_mode", 16'h0000, {14'h0, eeprom_pin_mode});
    idle(6);
    rd(DPR_ADDR_PORT_PINS_3_0, 8'hFF);
    rd(DPR_ADDR_PORT_PINS_7_4, 8'hFF);
    rd(DPR_ADDR_PORT_PINS_11_8, 8'hFF);
    rd(DPR_ADDR_PORT_PINS_14_12, 8'h77);
    for (int i = 0; i < 8; i++) rd(DPR_ADDR_RPB + 16'(i), 8'h00);
    rd(16'h2460, 8'h00);
    // Value writes on outputs, then inputs that read the pin level
    wr(DPR_ADDR_PORT_PINS_7_4, 8'hF5);
    idle(2);
    chk_sig("pin_out_7_4", 16'h0005, {12'h0, pin_out[7:4]});
    rnd = 15'($random(seed));
    ext_lvl = rnd;
    wr(DPR_ADDR_PORT_PINS_7_4, 8'h0A);
    idle(6);
    chk_sig("oe_7_4", 16'h000F, {12'h0, pin_oe_n[7:4]});
    rd(DPR_ADDR_PORT_PINS_7_4, {4'h0, rnd[7:4]});
    wr(DPR_ADDR_PORT_PINS_7_4, 8'hF3);
    idle(2);
    chk_sig("pin_out_7_4", 16'h0003, {12'h0, pin_out[7:4]});
    chk_sig("oe_7_4", 16'h0000, {12'h0, pin_oe_n[7:4]});
    // Every selector code on pin 4
    wr(DPR_ADDR_PORT_PINS_3_0, 8'h00);
    wr(DPR_ADDR_PORT_PINS_7_4, 8'h00);
    wr(DPR_ADDR_PORT_PINS_11_8, 8'h00);
    ext_lvl = 15'h0010;
    for (int c = 0; c < 6; c++) begin
      wr(DPR_ADDR_RD, {5'h0, 3'(c)});
      idle(6);
      chk_sig("res_q", {12'h0, res_exp(3'(c))}, {12'h0, res_q});
    end
    // Pin 11 and the pushbutton share the first interrupt
    wr(DPR_ADDR_RD, 8'h00);
    wr(DPR_ADDR_RA, 8'h40);
    wr(DPR_ADDR_RPB, 8'h04);
    rd(DPR_ADDR_RA, 8'h40);
    for (int k = 0; k < 4; k++) begin
      ext_lvl = {3'h0, k[1], 11'h0};
      pushbutton_input = k[0];
      idle(6);
      chk_sig("res_or", {12'h0, 2'b00, |k[1:0], 1'b0}, {12'h0, res_q});
    end
    // EEPROM modes and pin takeover
    for (int m = 0; m < 4; m++) begin
      wr(DPR_ADDR_EEX, {2'(m), 6'h0});
      chk_sig("ee_mode", 16'(m), {14'h0, eeprom_pin_mode});
      rd(DPR_ADDR_EEX, {2'(m), 6'h0});
    end
    ee_core = '{clk_out: 1'b1, data_out: 1'b0, data_oe_n: 1'b0};
    wr(DPR_ADDR_EEX, 8'h40);
    idle(2);
    chk_sig("oe_3_2", 16'h0000, {14'h0, pin_oe_n[3:2]});
    chk_sig("out_3_2", 16'h0001, {14'h0, pin_out[3:2]});
    ee_core.data_oe_n = 1'b1;
    for (int b = 0; b < 2; b++) begin
      ext_lvl = {11'h0, b[0], 3'h0};
      idle(6);
      chk_sig("oe_3", 16'h0001, {15'h0, pin_oe_n[3]});
      chk_sig("ee_in", 16'(b), {15'h0, eeprom_in_line_q});
    end
    wr(DPR_ADDR_PORT_PINS_11_8, 8'hF0);
    wr(DPR_ADDR_EEX, 8'hC0);
    for (int b = 0; b < 2; b++) begin
      ext_lvl = {6'h0, b[0], 4'h0, ~b[0], 3'h0};
      idle(6);
      chk_sig("oe_8", 16'h0001, {15'h0, pin_oe_n[8]});
      chk_sig("ee_in", 16'(b), {15'h0, eeprom_in_line_q});
    end
    wr(DPR_ADDR_EEX, 8'h00);
    idle(2);
    chk_sig("oe_3_2", 16'h0003, {14'h0, pin_oe_n[3:2]});
    // Energy pulse on pin 0, which the port holds as an input
    wr(DPR_ADDR_PULSE, 8'h80);
    rd(DPR_ADDR_PULSE, 8'h80);
    for (int p = 0; p < 2; p++) begin
      energy_pulse = p[0];
      idle(2);
      chk_sig("oe_0", 16'h0000, {15'h0, pin_oe_n[0]});
      chk_sig("out_0", 16'(p), {15'h0, pin_out[0]});
    end
    wr(DPR_ADDR_PULSE, 8'h00);
    idle(2);
    chk_sig("oe_0", 16'h0001, {15'h0, pin_oe_n[0]});
    idle(2);
    if (exp_q.size() != 0) err_total++;
    end_sim();
  end
endmodule : dpr_port_bench
`default_nettype wire
